/* rtl/mmb_defs.vh */
// mmb_defs.vh: constants for the mono mix and bass boost block
// assumes inclusion by the mmb design files only; definitions only
//
// Behaviour
// - select 11: both line outputs carry (L+R)/2, with boost.
// - select 00: left to left, right to right; only left is boosted.
// - select 01: left sample on both outputs, with boost.
// - select 10: right sample on both outputs, with boost.
// - boost path active only while boost enable and dac power are both 1.
// - boost enable 0: samples pass the boost stage at unity gain.
// - six-bit max level gives gain value/4; code 00 mutes, 3F is highest.
// - boost gain ramps gradually from its default toward the maximum level.
// - output above limiter threshold makes the limiter reduce applied boost.
// - highpass A(1-z^-1)/(1+Bz^-1), 8-bit A and B, running within 4 samples.
// - lowpass A(1+z^-1)/(1+Bz^-1), 8-bit A and B, running within 4 samples.
// - each bandpass (A/8)(1-z^-2)/(1-Bz^-1-Cz^-2), 8-bit A, 16-bit B and C.
// - all bandpass stages run within 4 samples of boost and power both on.
// - coefficients are two's complement; A scaled 2^7, bandpass B and C 2^13.
// - one mono signal goes through highpass, lowpass and three bandpass stages.
`ifndef MMB_DEFS_VH
`define MMB_DEFS_VH
`define MMB_ADR_CTRL      4'h0
`define MMB_ADR_LEVEL     4'h1
`define MMB_ADR_HP        4'h2
`define MMB_ADR_LP        4'h3
`define MMB_ADR_B1A       4'h4
`define MMB_ADR_B1BC      4'h5
`define MMB_ADR_B2A       4'h6
`define MMB_ADR_B2BC      4'h7
`define MMB_ADR_B3A       4'h8
`define MMB_ADR_B3BC      4'h9
`define MMB_ADR_STAT      4'hA
`define MMB_ADR_LIMIT     4'hB
`define MMB_MONO_STRAIGHT 2'h0
`define MMB_MONO_LEFT     2'h1
`define MMB_MONO_RIGHT    2'h2
`define MMB_MONO_AVG      2'h3
`define MMB_CTRL_MONO_LO  0
`define MMB_CTRL_BOOST    2
`define MMB_CTRL_DACPU    3
`define MMB_SHIFT_A       7
`define MMB_SHIFT_BC      13
`define MMB_SHIFT_BAND    3
`define MMB_SHIFT_GAIN    2
`define MMB_GAIN_UNITY    6'h04
`define MMB_START_DELAY   3'h3
`define MMB_RAMP_SAMPLES  8'h10
`define MMB_LIMIT_RESET   24'h600000
`endif

/* rtl/mmb_biquad.v */
// mmb_biquad.v: one second-order section with registered output, y = b0x+b1x1+b2x2-a1y1-a2y2
// assumes coefficients are two's complement in Q(frac); advance is a one-cycle sample strobe
`timescale 1ns/1ps
`include "mmb_defs.vh"
module mmb_biquad #(
  parameter DW   = 24,
  parameter CW   = 18,
  parameter FRAC = 13
) (
  input  wire                 clk_i,
  input  wire                 rst_i,
  input  wire                 clr_i,
  input  wire                 adv_i,
  input  wire signed [DW-1:0] x_i,
  input  wire signed [CW-1:0] b0_i,
  input  wire signed [CW-1:0] b1_i,
  input  wire signed [CW-1:0] b2_i,
  input  wire signed [CW-1:0] a1_i,
  input  wire signed [CW-1:0] a2_i,
  output reg  signed [DW-1:0] y_o
);
  localparam AW = DW + CW + 3;
  reg  signed [DW-1:0] x1_r;
  reg  signed [DW-1:0] x2_r;
  reg  signed [DW-1:0] y2_r;
  wire signed [AW-1:0] acc;
  wire signed [AW-1:0] scl;
  wire signed [DW-1:0] y_nxt;
  assign acc = b0_i * x_i + b1_i * x1_r + b2_i * x2_r - a1_i * y_o - a2_i * y2_r;
  assign scl = acc >>> FRAC;
  // saturate to the data width so a marginal pole cannot wrap
  assign y_nxt = (scl > $signed({{(AW-DW){1'b0}}, 1'b0, {(DW-1){1'b1}}})) ? {1'b0, {(DW-1){1'b1}}} :
                 (scl < $signed({{(AW-DW){1'b1}}, 1'b1, {(DW-1){1'b0}}})) ? {1'b1, {(DW-1){1'b0}}} :
                 scl[DW-1:0];
  always @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      x1_r <= {DW{1'b0}};
      x2_r <= {DW{1'b0}};
      y_o  <= {DW{1'b0}};
      y2_r <= {DW{1'b0}};
    end else if (adv_i) begin
      x1_r <= x_i;
      x2_r <= x1_r;
      y2_r <= y_o;
      y_o  <= y_nxt;
    end
  end
endmodule

/* rtl/mmb_top.v */
// mmb_top.v: mono select router and mono bass boost, registers on classic wishbone
// assumes fs strobe and samples come from logic on clk_i; one sample per fs strobe
`timescale 1ns/1ps
`include "mmb_defs.vh"
module mmb_top #(
  parameter DW = 24
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire          wb_cyc_i,
  input  wire          wb_stb_i,
  input  wire          wb_we_i,
  input  wire [3:0]    wb_sel_i,
  input  wire [5:2]    wb_adr_i,
  input  wire [31:0]   wb_dat_i,
  output reg  [31:0]   wb_dat_o,
  output reg           wb_ack_o,
  input  wire          fs_stb_i,
  input  wire [DW-1:0] left_in_i,
  input  wire [DW-1:0] right_in_i,
  output reg  [DW-1:0] left_line_out_o,
  output reg  [DW-1:0] right_line_out_o,
  output reg           out_valid_o
);
  localparam AW = DW + 10;

  // software registers
  reg  [1:0]  mono_select_r;
  reg         boost_enable_r;
  reg         dac_power_up_r;
  reg  [5:0]  boost_max_level_r;
  reg  [7:0]  highpass_coef_a_r;
  reg  [7:0]  highpass_coef_b_r;
  reg  [7:0]  lowpass_coef_a_r;
  reg  [7:0]  lowpass_coef_b_r;
  reg  [23:0] band_coef_a_r;
  reg  [95:0] band_coef_bc_r;
  reg  [DW-1:0] limit_r;

  // processing state
  reg  [2:0]  start_cnt_r;
  reg  [5:0]  gain_r;
  reg  [7:0]  ramp_cnt_r;
  reg         lim_hit_r;
  reg         adv_r;
  reg         stage_r;
  reg  signed [DW-1:0] mono_r;

  wire boost_on = boost_enable_r & dac_power_up_r;
  wire running  = boost_on && (start_cnt_r == `MMB_START_DELAY);
  wire wb_hit   = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  function [31:0] mmb_merge;
    input [31:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        mmb_merge[8*k +: 8] = sel[k] ? dat[8*k +: 8] : old[8*k +: 8];
    end
  endfunction

  wire [31:0] ctrl_rd = {26'h0, lim_hit_r, running, dac_power_up_r, boost_enable_r, mono_select_r};
  wire [31:0] ctrl_wr = mmb_merge(ctrl_rd, wb_dat_i, wb_sel_i);
  wire [31:0] lvl_wr  = mmb_merge({26'h0, boost_max_level_r}, wb_dat_i, wb_sel_i);
  wire [31:0] hp_wr   = mmb_merge({16'h0, highpass_coef_b_r, highpass_coef_a_r}, wb_dat_i, wb_sel_i);
  wire [31:0] lp_wr   = mmb_merge({16'h0, lowpass_coef_b_r, lowpass_coef_a_r}, wb_dat_i, wb_sel_i);
  wire [31:0] lim_wr  = mmb_merge({{(32-DW){1'b0}}, limit_r}, wb_dat_i, wb_sel_i);
  wire [31:0] b1a_wr  = mmb_merge({24'h0, band_coef_a_r[7:0]}, wb_dat_i, wb_sel_i);
  wire [31:0] b2a_wr  = mmb_merge({24'h0, band_coef_a_r[15:8]}, wb_dat_i, wb_sel_i);
  wire [31:0] b3a_wr  = mmb_merge({24'h0, band_coef_a_r[23:16]}, wb_dat_i, wb_sel_i);

  // register writes; coefficient hygiene during operation is software's duty
  always @(posedge clk_i) begin
    if (rst_i) begin
      mono_select_r     <= `MMB_MONO_STRAIGHT;
      boost_enable_r    <= 1'b0;
      dac_power_up_r    <= 1'b0;
      boost_max_level_r <= 6'h00;
      highpass_coef_a_r <= 8'h00;
      highpass_coef_b_r <= 8'h00;
      lowpass_coef_a_r  <= 8'h00;
      lowpass_coef_b_r  <= 8'h00;
      band_coef_a_r     <= 24'h0;
      band_coef_bc_r    <= 96'h0;
      limit_r           <= `MMB_LIMIT_RESET;
    end else if (wb_hit && wb_we_i) begin
      case (wb_adr_i)
        `MMB_ADR_CTRL: begin
          mono_select_r  <= ctrl_wr[`MMB_CTRL_MONO_LO +: 2];
          boost_enable_r <= ctrl_wr[`MMB_CTRL_BOOST];
          dac_power_up_r <= ctrl_wr[`MMB_CTRL_DACPU];
        end
        `MMB_ADR_LEVEL: boost_max_level_r <= lvl_wr[5:0];
        `MMB_ADR_HP: begin
          highpass_coef_a_r <= hp_wr[7:0];
          highpass_coef_b_r <= hp_wr[15:8];
        end
        `MMB_ADR_LP: begin
          lowpass_coef_a_r <= lp_wr[7:0];
          lowpass_coef_b_r <= lp_wr[15:8];
        end
        `MMB_ADR_B1A:  band_coef_a_r[7:0]    <= b1a_wr[7:0];
        `MMB_ADR_B2A:  band_coef_a_r[15:8]   <= b2a_wr[7:0];
        `MMB_ADR_B3A:  band_coef_a_r[23:16]  <= b3a_wr[7:0];
        `MMB_ADR_B1BC: band_coef_bc_r[31:0]  <= mmb_merge(band_coef_bc_r[31:0], wb_dat_i, wb_sel_i);
        `MMB_ADR_B2BC: band_coef_bc_r[63:32] <= mmb_merge(band_coef_bc_r[63:32], wb_dat_i, wb_sel_i);
        `MMB_ADR_B3BC: band_coef_bc_r[95:64] <= mmb_merge(band_coef_bc_r[95:64], wb_dat_i, wb_sel_i);
        `MMB_ADR_LIMIT: limit_r <= lim_wr[DW-1:0];
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero and are still acknowledged
  reg [31:0] rd_nxt;
  always @* begin
    case (wb_adr_i)
      `MMB_ADR_CTRL:  rd_nxt = ctrl_rd;
      `MMB_ADR_LEVEL: rd_nxt = {26'h0, boost_max_level_r};
      `MMB_ADR_HP:    rd_nxt = {16'h0, highpass_coef_b_r, highpass_coef_a_r};
      `MMB_ADR_LP:    rd_nxt = {16'h0, lowpass_coef_b_r, lowpass_coef_a_r};
      `MMB_ADR_B1A:   rd_nxt = {24'h0, band_coef_a_r[7:0]};
      `MMB_ADR_B2A:   rd_nxt = {24'h0, band_coef_a_r[15:8]};
      `MMB_ADR_B3A:   rd_nxt = {24'h0, band_coef_a_r[23:16]};
      `MMB_ADR_B1BC:  rd_nxt = band_coef_bc_r[31:0];
      `MMB_ADR_B2BC:  rd_nxt = band_coef_bc_r[63:32];
      `MMB_ADR_B3BC:  rd_nxt = band_coef_bc_r[95:64];
      `MMB_ADR_STAT:  rd_nxt = {16'h0, 2'h0, gain_r, ramp_cnt_r};
      `MMB_ADR_LIMIT: rd_nxt = {{(32-DW){1'b0}}, limit_r};
      default:        rd_nxt = 32'h0;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? rd_nxt : 32'h0;
    end
  end

  // mono source for the boost: left in straight/left mode, right in right mode, else average
  wire signed [DW:0] sum_lr = $signed({left_in_i[DW-1], left_in_i}) + $signed({right_in_i[DW-1], right_in_i});
  wire signed [DW-1:0] avg_lr = sum_lr[DW:1];
  reg  signed [DW-1:0] src;
  always @* begin
    case (mono_select_r)
      `MMB_MONO_STRAIGHT: src = left_in_i;
      `MMB_MONO_LEFT:     src = left_in_i;
      `MMB_MONO_RIGHT:    src = right_in_i;
      default:            src = avg_lr;
    endcase
  end

  // stage chain: highpass -> lowpass, plus three parallel bandpass fed from mono_r, once per sample
  wire signed [DW-1:0] hp_y;
  wire signed [DW-1:0] lp_y;
  wire signed [3*DW-1:0] bp_y;
  wire clr = ~running;

  mmb_biquad #(.DW(DW), .CW(18), .FRAC(`MMB_SHIFT_A)) u_hp (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .clr_i (clr),
    .adv_i (adv_r),
    .x_i   (mono_r),
    .b0_i  ({{10{highpass_coef_a_r[7]}}, highpass_coef_a_r}),
    .b1_i  (-{{10{highpass_coef_a_r[7]}}, highpass_coef_a_r}),
    .b2_i  (18'sh0),
    .a1_i  ({{10{highpass_coef_b_r[7]}}, highpass_coef_b_r}),
    .a2_i  (18'sh0),
    .y_o   (hp_y)
  );

  mmb_biquad #(.DW(DW), .CW(18), .FRAC(`MMB_SHIFT_A)) u_lp (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .clr_i (clr),
    .adv_i (adv_r),
    .x_i   (hp_y),
    .b0_i  ({{10{lowpass_coef_a_r[7]}}, lowpass_coef_a_r}),
    .b1_i  ({{10{lowpass_coef_a_r[7]}}, lowpass_coef_a_r}),
    .b2_i  (18'sh0),
    .a1_i  ({{10{lowpass_coef_b_r[7]}}, lowpass_coef_b_r}),
    .a2_i  (18'sh0),
    .y_o   (lp_y)
  );

  // bandpass A is Q7 and carries the 1/8, so b0 = A * 2^13 / (2^7 * 8) = A * 8 in Q13
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_band
      wire signed [17:0] a_q13 = {{7{band_coef_a_r[8*g+7]}}, band_coef_a_r[8*g +: 8], 3'h0};
      wire signed [17:0] b_q13 = {{2{band_coef_bc_r[32*g+15]}}, band_coef_bc_r[32*g +: 16]};
      wire signed [17:0] c_q13 = {{2{band_coef_bc_r[32*g+31]}}, band_coef_bc_r[32*g+16 +: 16]};
      mmb_biquad #(.DW(DW), .CW(18), .FRAC(`MMB_SHIFT_BC)) u_bp (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .clr_i (clr),
        .adv_i (adv_r),
        .x_i   (mono_r),
        .b0_i  (a_q13),
        .b1_i  (18'sh0),
        .b2_i  (-a_q13),
        .a1_i  (-b_q13),
        .a2_i  (-c_q13),
        .y_o   (bp_y[DW*g +: DW])
      );
    end
  endgenerate

  // mix: shaped path plus resonances, scaled by gain/4
  wire signed [AW-1:0] mix = $signed(lp_y) + $signed(bp_y[DW-1:0]) + $signed(bp_y[2*DW-1:DW])
                           + $signed(bp_y[3*DW-1:2*DW]);
  wire signed [AW+6:0] prod  = mix * $signed({1'b0, gain_r});
  wire signed [AW+6:0] boost = prod >>> `MMB_SHIFT_GAIN;
  wire signed [DW:0]   lim_p = $signed({1'b0, limit_r});
  wire over = (boost > lim_p) || (boost < -lim_p);
  wire signed [DW-1:0] boost_sat = (boost > lim_p) ? limit_r : (boost < -lim_p) ? -limit_r : boost[DW-1:0];
  wire signed [DW-1:0] boost_out = running ? boost_sat : mono_r;

  // sequencing: capture, filter advance, output, one fs at a time
  always @(posedge clk_i) begin
    if (rst_i) begin
      mono_r           <= {DW{1'b0}};
      adv_r            <= 1'b0;
      stage_r          <= 1'b0;
      start_cnt_r      <= 3'h0;
      gain_r           <= `MMB_GAIN_UNITY;
      ramp_cnt_r       <= 8'h00;
      lim_hit_r        <= 1'b0;
      left_line_out_o  <= {DW{1'b0}};
      right_line_out_o <= {DW{1'b0}};
      out_valid_o      <= 1'b0;
    end else begin
      adv_r       <= fs_stb_i;
      stage_r     <= adv_r;
      out_valid_o <= stage_r;
      if (fs_stb_i)
        mono_r <= src;
      if (!boost_on) begin
        start_cnt_r <= 3'h0;
        gain_r      <= `MMB_GAIN_UNITY;
        ramp_cnt_r  <= 8'h00;
      end else if (fs_stb_i && start_cnt_r != `MMB_START_DELAY) begin
        start_cnt_r <= start_cnt_r + 3'h1;
      end
      if (stage_r && running) begin
        lim_hit_r <= over;
        if (over && gain_r != 6'h00) begin
          gain_r     <= gain_r - 6'h01;
          ramp_cnt_r <= 8'h00;
        end else if (ramp_cnt_r == `MMB_RAMP_SAMPLES) begin
          ramp_cnt_r <= 8'h00;
          if (gain_r < boost_max_level_r)
            gain_r <= gain_r + 6'h01;
          else if (gain_r > boost_max_level_r)
            gain_r <= gain_r - 6'h01;
        end else begin
          ramp_cnt_r <= ramp_cnt_r + 8'h01;
        end
      end
      if (stage_r) begin
        case (mono_select_r)
          `MMB_MONO_STRAIGHT: begin
            left_line_out_o  <= boost_out;
            right_line_out_o <= right_in_i;
          end
          `MMB_MONO_LEFT, `MMB_MONO_RIGHT: begin
            left_line_out_o  <= boost_out;
            right_line_out_o <= boost_out;
          end
          default: begin
            left_line_out_o  <= boost_out;
            right_line_out_o <= boost_out;
          end
        endcase
      end
    end
  end
endmodule

/* tb/mmb_checker.sv */
// mmb_checker.sv: port-level assertions for mmb_top
// assumes ctrl is written at word 0 with full byte lanes; mode checks need boost off
`timescale 1ns/1ps
module mmb_checker #(
  parameter DW = 24
) (
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_we_i,
  input wire logic [3:0]    wb_sel_i,
  input wire logic [5:2]    wb_adr_i,
  input wire logic [31:0]   wb_dat_i,
  input wire logic [31:0]   wb_dat_o,
  input wire logic          wb_ack_o,
  input wire logic          fs_stb_i,
  input wire logic [DW-1:0] left_in_i,
  input wire logic [DW-1:0] right_in_i,
  input wire logic [DW-1:0] left_line_out_o,
  input wire logic [DW-1:0] right_line_out_o,
  input wire logic          out_valid_o
);
  logic [1:0]    mode_r;
  logic          boost_r;
  logic [1:0]    mode_cap_r;
  logic          off_cap_r;
  logic [DW-1:0] l_cap_r;
  logic [DW-1:0] r_cap_r;
  logic [DW:0]   sum_w;
  logic          plain_w;
  assign sum_w   = {l_cap_r[DW-1], l_cap_r} + {r_cap_r[DW-1], r_cap_r};
  assign plain_w = out_valid_o && off_cap_r && !boost_r;
  // shadow of the control word, taken at the acknowledging edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_r  <= 2'h0;
      boost_r <= 1'b0;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0]) begin
      mode_r  <= wb_dat_i[1:0];
      boost_r <= wb_dat_i[2];
    end
  end
  always @(posedge clk_i) begin
    if (fs_stb_i) begin
      l_cap_r    <= left_in_i;
      r_cap_r    <= right_in_i;
      mode_cap_r <= mode_r;
      off_cap_r  <= !boost_r;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
  sequence s_sample; fs_stb_i ##3 out_valid_o; endsequence
  a_ack_answer: assert property (s_req |-> ##[1:2] s_ack) else $error("ack late or held");
  a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
  a_valid_delay: assert property (fs_stb_i |-> s_sample) else $error("valid not 3 after strobe");
  a_valid_cause: assert property (out_valid_o |-> $past(fs_stb_i, 3)) else $error("stray valid");
  a_out_hold: assert property ($changed(left_line_out_o) || $changed(right_line_out_o) |-> out_valid_o)
    else $error("outputs moved without valid");
  a_mode_straight: assert property (plain_w && mode_cap_r == 2'h0 |->
    left_line_out_o == l_cap_r && right_line_out_o == r_cap_r) else $error("straight route wrong");
  a_mode_left: assert property (plain_w && mode_cap_r == 2'h1 |->
    left_line_out_o == l_cap_r && right_line_out_o == l_cap_r) else $error("left copy wrong");
  a_mode_right: assert property (plain_w && mode_cap_r == 2'h2 |->
    left_line_out_o == r_cap_r && right_line_out_o == r_cap_r) else $error("right copy wrong");
  a_mode_avg: assert property (plain_w && mode_cap_r == 2'h3 |->
    left_line_out_o == sum_w[DW:1] && right_line_out_o == sum_w[DW:1]) else $error("average wrong");
endmodule
bind mmb_top mmb_checker #(.DW(DW)) mmb_checker_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fs_stb_i(fs_stb_i), .left_in_i(left_in_i),
  .right_in_i(right_in_i), .left_line_out_o(left_line_out_o), .right_line_out_o(right_line_out_o),
  .out_valid_o(out_valid_o));

/* tb/mmb_src_model.sv */
// mmb_src_model.sv: sample source in front of mmb_top, one strobe per request
// assumes requests are held until the strobe is seen; strobes at least 8 cycles apart
`timescale 1ns/1ps
module mmb_src_model #(
  parameter DW = 24
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          req_i,
  input  wire logic [DW-1:0] l_i,
  input  wire logic [DW-1:0] r_i,
  output logic               fs_stb_o,
  output logic [DW-1:0]      left_o,
  output logic [DW-1:0]      right_o
);
  logic [2:0] gap_r;
  always @(posedge clk_i) begin
    if (rst_i) begin
      fs_stb_o <= 1'b0;
      gap_r    <= 3'h0;
      left_o   <= '0;
      right_o  <= '0;
    end else begin
      fs_stb_o <= req_i && gap_r == 3'h0;
      if (req_i && gap_r == 3'h0) begin
        gap_r   <= 3'h7;
        left_o  <= l_i;
        right_o <= r_i;
      end else if (gap_r != 3'h0) begin
        gap_r <= gap_r - 3'h1;
      end
      // past the hold window the data no longer means anything
      if (gap_r == 3'h4) begin
        left_o  <= ~left_o;
        right_o <= ~right_o;
      end
    end
  end
endmodule

/* tb/tb_top.sv */
// tb_top.sv: self-checking bench for mmb_top with a sample source model
// assumes all coefficients stay at reset zero, so a running boost path outputs zero
`timescale 1ns/1ps
module tb_top;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, req, fs_stb, out_valid_o;
  logic [3:0]  wb_sel_i, wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [23:0] sl, sr, left_in, right_in, left_line_out, right_line_out;
  logic [48:0] notes[$];
  logic [48:0] nt;
  int          n_mismatch, n_tests;
  mmb_top mmb_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .fs_stb_i(fs_stb), .left_in_i(left_in), .right_in_i(right_in),
    .left_line_out_o(left_line_out), .right_line_out_o(right_line_out), .out_valid_o(out_valid_o));
  mmb_src_model mmb_src_model_i (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .l_i(sl), .r_i(sr),
    .fs_stb_o(fs_stb), .left_o(left_in), .right_o(right_in));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (notes.size() != 0) n_mismatch++;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) n_mismatch++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  function automatic logic [47:0] exp_of(input logic [1:0] m, input logic [23:0] l, input logic [23:0] r);
    logic [24:0] s;
    s = {l[23], l} + {r[23], r};
    case (m)
      2'h0: exp_of = {l, r};
      2'h1: exp_of = {l, l};
      2'h2: exp_of = {r, r};
      default: exp_of = {s[24:1], s[24:1]};
    endcase
  endfunction
  task automatic send(input logic [23:0] l, input logic [23:0] r, input logic [1:0] m, input logic care,
                      input logic zero);
    int n;
    notes.push_back({care, zero ? 48'h0 : exp_of(m, l, r)});
    @(posedge clk_i);
    req <= 1'b1;
    sl  <= l;
    sr  <= r;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (fs_stb !== 1'b1 && n < 20);
    if (fs_stb !== 1'b1) n_mismatch++;
    req <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic run(input int k, input int m, input int skip, input logic zero);
    for (int i = 0; i < k; i++) begin
      send(24'($urandom), 24'($urandom), m[1:0], i >= skip, zero);
    end
  endtask
  // result side: every valid output consumes the oldest note
  always @(posedge clk_i) begin
    if (out_valid_o === 1'b1) begin
      if (notes.size() == 0) begin
        check("spare output", 32'h1, 32'h0);
      end else begin
        nt = notes.pop_front();
        if (nt[48]) check("left out", {8'h0, left_line_out}, {8'h0, nt[47:24]});
        if (nt[48]) check("right out", {8'h0, right_line_out}, {8'h0, nt[23:0]});
      end
    end
  end
  initial begin
    #(40 * 20000);
    n_mismatch++;
    give_verdict;
  end
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, req} = 5'h10;
    {wb_sel_i, wb_adr_i, wb_dat_i, sl, sr} = '0;
    n_mismatch = 0;
    n_tests = 0;
    void'($urandom(979));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    check("ctrl reset", rd, 32'h0);
    wb(1'b0, 4'hB, 32'h0);
    check("limit reset", rd, 32'h00600000);
    wb(1'b1, 4'hC, 32'hFFFFFFFF);
    wb(1'b0, 4'hC, 32'h0);
    check("unmapped", rd, 32'h0);
    wb(1'b1, 4'h1, 32'hFFFFFFFF);
    wb(1'b0, 4'h1, 32'h0);
    check("level width", rd, 32'h3F);
    $display("test registers done");
    for (int m = 0; m < 5; m++) begin
      wb(1'b1, 4'h0, (m < 4) ? (32'h8 | m) : 32'h7);
      run(6, (m < 4) ? m : 3, 0, 1'b0);
    end
    $display("test mono select done");
    wb(1'b1, 4'h0, 32'h3);
    // coefficients stay at reset zero, inside the legal settings
    wb(1'b1, 4'h1, 32'h6);
    wb(1'b1, 4'h0, 32'hF);
    run(4, 3, 4, 1'b1);
    wb(1'b0, 4'h0, 32'h0);
    check("running", {31'h0, rd[4]}, 32'h1);
    wb(1'b0, 4'hA, 32'h0);
    check("gain start", {26'h0, rd[13:8]}, 32'h4);
    run(40, 3, 0, 1'b1);
    wb(1'b0, 4'hA, 32'h0);
    check("gain ramped", {26'h0, rd[13:8]}, 32'h6);
    wb(1'b1, 4'h0, 32'h3);
    wb(1'b1, 4'h1, 32'h0);
    wb(1'b1, 4'h0, 32'hF);
    run(110, 3, 4, 1'b1);
    wb(1'b0, 4'hA, 32'h0);
    check("gain mute", {26'h0, rd[13:8]}, 32'h0);
    wb(1'b1, 4'h0, 32'hB);
    run(8, 3, 1, 1'b0);
    $display("test bass boost done");
    repeat (8) @(posedge clk_i);
    give_verdict;
  end
endmodule
